// ===== src/ctm_timer.sv
// Compact 10-bit timer: counter, two comparators, output pin pair, byte register port
//
// Contract
// - 10-bit up-counter steps on each selected clock edge while switched on and not paused.
// - Counter equal to a comparator is a match: interrupt, maybe clear, maybe pin.
// - Period value meets counter bits 9..7; compare A meets all ten bits.
// - Separate interrupt pulses for compare A match and period match.
// - Counter clears on overflow or associated comparator match, raising its interrupt.
// - Software can only zero the counter, by raising the on bit.
// - Three-bit field selects system ratio, high clock ratio, sub clock or pin.
// - External pin counts on rising or falling edge as configured.
// - Modes are compare match output, timer/event counter and PWM output.
// - Two output pins, second always the inverse of the first.
// - Compare mode sets pin high, low or toggles on compare A match.
// - PWM waveform appears on the same output pin pair.
// - Low byte write of compare A or period only loads the holding buffer.
// - High byte write loads high byte and copies buffer to low byte.
// - High byte read returns it and captures the low byte into the buffer.
// - Low byte read returns the holding buffer, not the live byte.
// - Select codes: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// - Period code n gives n*128 clocks; code zero gives 1024 clocks.
// - Mode 00 compare, 10 PWM, 11 timer/counter, 01 undefined.
// - In compare or PWM mode, raising the on bit restores the initial level.
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_timer (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [`CTM_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic compact_ext_clock_pin_i,
  input wire logic sub_clock_i,
  output logic timer_output_pin_o,
  output logic timer_output_inverted_pin_o,
  output logic match_a_irq_o,
  output logic match_p_irq_o
);

  ctm_pkg::ctm_state_t st;
  ctm_pkg::ctm_state_t next_st;

  logic en_div4;
  logic en_div16;
  logic en_div64;
  logic [1:0] pins_sync;

  // Decoded control fields
  logic pause;
  logic counter_on_bit;
  logic [2:0] clock_select_field;
  logic [2:0] period_compare_value;
  logic [1:0] operating_mode_field;
  logic [1:0] out_func;
  logic initial_level_bit;
  logic polarity;
  logic duty_swap;
  logic clear_on_a;

  // Counter datapath
  logic tick;
  logic on_rise;
  logic ext_now;
  logic sub_now;
  logic [10:0] cnt_inc;
  logic [10:0] period_target;
  logic match_a;
  logic match_p;
  logic clr_a;
  logic clr_p;
  logic pwm_mode;
  logic cmp_mode;
  logic pwm_active;
  logic [9:0] duty_value;

  ctm_prescale u_prescale (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .en_div4_o(en_div4),
    .en_div16_o(en_div16),
    .en_div64_o(en_div64)
  );

  // Bit 0 external clock pin, bit 1 sub clock; both arrive from other domains
  ctm_sync2 u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({sub_clock_i, compact_ext_clock_pin_i}),
    .sync_o(pins_sync)
  );

  assign pause = st.ctrl0[`CTM_C0_PAU];
  assign counter_on_bit = st.ctrl0[`CTM_C0_ON];
  assign clock_select_field = st.ctrl0[`CTM_C0_CK_HI:`CTM_C0_CK_LO];
  assign period_compare_value = st.ctrl0[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
  assign operating_mode_field = st.ctrl1[`CTM_C1_M_HI:`CTM_C1_M_LO];
  assign out_func = st.ctrl1[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  assign initial_level_bit = st.ctrl1[`CTM_C1_OC];
  assign polarity = st.ctrl1[`CTM_C1_POL];
  assign duty_swap = st.ctrl1[`CTM_C1_DPX];
  assign clear_on_a = st.ctrl1[`CTM_C1_CCLR];

  assign ext_now = pins_sync[0];
  assign sub_now = pins_sync[1];
  assign on_rise = counter_on_bit & ~st.on_q;
  assign cmp_mode = (operating_mode_field == `CTM_MODE_CMP);
  assign pwm_mode = (operating_mode_field == `CTM_MODE_PWM);

  // Clock source selection; high clock is taken as the system clock here
  always_comb begin
    case (clock_select_field)
      `CTM_CK_SYS_DIV4: tick = en_div4;
      `CTM_CK_SYS: tick = 1'b1;
      `CTM_CK_HI_DIV16: tick = en_div16;
      `CTM_CK_HI_DIV64: tick = en_div64;
      `CTM_CK_SUB_A,
      `CTM_CK_SUB_B: tick = sub_now & ~st.sub_q;
      `CTM_CK_EXT_RISE: tick = ext_now & ~st.ext_q;
      `CTM_CK_EXT_FALL: tick = ~ext_now & st.ext_q;
      default: tick = 1'b0;
    endcase
  end

  // Matches are judged on the value the counter is about to take
  assign cnt_inc = {1'b0, st.count} + `CTM_COUNT_ONE;
  assign period_target = (period_compare_value == 3'h0) ? `CTM_FULL_PERIOD :
                         {1'b0, period_compare_value, 7'h00};
  assign match_a = tick & (cnt_inc[9:0] == st.cmp_a);
  assign match_p = tick & (cnt_inc == period_target);

  // In PWM the duty swap bit chooses which comparator sets the period
  assign clr_a = match_a & (pwm_mode ? duty_swap : clear_on_a);
  assign clr_p = match_p & (pwm_mode ? ~duty_swap : ~clear_on_a);

  assign duty_value = duty_swap ? {period_compare_value, 7'h00} : st.cmp_a;
  assign pwm_active = (st.count < duty_value);

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.irq_a = 1'b0;
    next_st.irq_p = 1'b0;
    next_st.on_q = counter_on_bit;
    next_st.ext_q = ext_now;
    next_st.sub_q = sub_now;

    // Counter
    if (on_rise) begin
      next_st.count = 10'h000;
    end else if (counter_on_bit && !pause && tick) begin
      if (clr_a || clr_p) begin
        next_st.count = 10'h000;
      end else begin
        next_st.count = cnt_inc[9:0];
      end
      next_st.irq_a = match_a;
      next_st.irq_p = match_p;
    end

    // Output level before polarity
    if (on_rise && (cmp_mode || pwm_mode)) begin
      next_st.out_lvl = initial_level_bit;
    end else if (counter_on_bit) begin
      case (operating_mode_field)
        `CTM_MODE_CMP: begin
          if (match_a && !pause) begin
            case (out_func)
              `CTM_IO_LOW: next_st.out_lvl = 1'b0;
              `CTM_IO_HIGH: next_st.out_lvl = 1'b1;
              `CTM_IO_TOGGLE: next_st.out_lvl = ~st.out_lvl;
              default: next_st.out_lvl = st.out_lvl;
            endcase
          end
        end
        `CTM_MODE_PWM: begin
          case (out_func)
            `CTM_PWM_ACTIVE: next_st.out_lvl = initial_level_bit;
            `CTM_PWM_WAVE: next_st.out_lvl = pwm_active ? initial_level_bit : ~initial_level_bit;
            default: next_st.out_lvl = ~initial_level_bit;
          endcase
        end
        // Timer/counter mode leaves the pin alone
        default: next_st.out_lvl = st.out_lvl;
      endcase
    end
    next_st.pin = (cmp_mode || pwm_mode) ? (next_st.out_lvl ^ polarity) : st.pin;

    // Register port
    if (reg_wr_i) begin
      case (reg_addr_i)
        `CTM_ADDR_C0: next_st.ctrl0 = reg_wdata_i;
        `CTM_ADDR_C1: next_st.ctrl1 = reg_wdata_i;
        `CTM_ADDR_AL,
        `CTM_ADDR_PL: next_st.hold_buf = reg_wdata_i;
        `CTM_ADDR_AH: next_st.cmp_a = {reg_wdata_i[1:0], st.hold_buf};
        `CTM_ADDR_PH: begin
          // Only period bits 9..7 exist; buffer bit 7 is the lowest of them
          next_st.ctrl0[`CTM_C0_RP_HI:`CTM_C0_RP_LO] = {reg_wdata_i[1:0], st.hold_buf[7]};
        end
        // Count bytes are read only
        default: next_st.hold_buf = st.hold_buf;
      endcase
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CTM_ADDR_C0: next_st.rdata = st.ctrl0;
        `CTM_ADDR_C1: next_st.rdata = st.ctrl1;
        `CTM_ADDR_DH: begin
          next_st.rdata = {6'h00, st.count[9:8]};
          next_st.hold_buf = st.count[7:0];
        end
        `CTM_ADDR_AH: begin
          next_st.rdata = {6'h00, st.cmp_a[9:8]};
          next_st.hold_buf = st.cmp_a[7:0];
        end
        `CTM_ADDR_PH: begin
          next_st.rdata = {6'h00, period_compare_value[2:1]};
          next_st.hold_buf = {period_compare_value[0], 7'h00};
        end
        `CTM_ADDR_DL,
        `CTM_ADDR_AL,
        `CTM_ADDR_PL: next_st.rdata = st.hold_buf;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.ctrl0 <= `CTM_C0_RST;
      st.ctrl1 <= `CTM_C1_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign timer_output_pin_o = st.pin;
  assign timer_output_inverted_pin_o = ~st.pin;
  assign match_a_irq_o = st.irq_a;
  assign match_p_irq_o = st.irq_p;

endmodule // ctm_timer

// ===== src/ctm_cfg.svh
// Register map, field positions, codes and reset values of the compact timer
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

`define CTM_ADDR_W 3
`define CTM_ADDR_C0 3'h0
`define CTM_ADDR_C1 3'h1
`define CTM_ADDR_DL 3'h2
`define CTM_ADDR_DH 3'h3
`define CTM_ADDR_AL 3'h4
`define CTM_ADDR_AH 3'h5
`define CTM_ADDR_PL 3'h6
`define CTM_ADDR_PH 3'h7

`define CTM_C0_RST 8'h00
`define CTM_C1_RST 8'h00

`define CTM_C0_PAU 7
`define CTM_C0_CK_HI 6
`define CTM_C0_CK_LO 4
`define CTM_C0_ON 3
`define CTM_C0_RP_HI 2
`define CTM_C0_RP_LO 0

`define CTM_C1_M_HI 7
`define CTM_C1_M_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0

`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3

`define CTM_CK_SYS_DIV4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_HI_DIV16 3'h2
`define CTM_CK_HI_DIV64 3'h3
`define CTM_CK_SUB_A 3'h4
`define CTM_CK_SUB_B 3'h5
`define CTM_CK_EXT_RISE 3'h6
`define CTM_CK_EXT_FALL 3'h7

`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOGGLE 2'h3
`define CTM_PWM_INACTIVE 2'h0
`define CTM_PWM_ACTIVE 2'h1
`define CTM_PWM_WAVE 2'h2

`define CTM_DIV4_MASK 6'h03
`define CTM_DIV16_MASK 6'h0F
`define CTM_DIV64_MASK 6'h3F

`define CTM_FULL_PERIOD 11'h400
`define CTM_COUNT_ONE 11'h001

`endif

// ===== src/ctm_pkg.sv
// State types of the compact timer modules
package ctm_pkg;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } ctm_sync_t;

  typedef struct packed {
    logic [5:0] div;
    logic en_div4;
    logic en_div16;
    logic en_div64;
  } ctm_presc_t;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] cmp_a;
    logic [9:0] count;
    logic [7:0] hold_buf;
    logic [7:0] rdata;
    logic on_q;
    logic ext_q;
    logic sub_q;
    logic out_lvl;
    logic pin;
    logic irq_a;
    logic irq_p;
  } ctm_state_t;

endpackage

// ===== src/ctm_sync2.sv
// Two-stage synchroniser for the external clock pin and the sub clock
`timescale 1ns/1ps
module ctm_sync2 (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);

  ctm_pkg::ctm_sync_t st;
  ctm_pkg::ctm_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.stage1 = async_i;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stage2;

endmodule // ctm_sync2

// ===== src/ctm_prescale.sv
// Divider giving one-cycle enables at the system clock /4, /16 and /64
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_prescale (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  output logic en_div4_o,
  output logic en_div16_o,
  output logic en_div64_o
);

  ctm_pkg::ctm_presc_t st;
  ctm_pkg::ctm_presc_t next_st;

  always_comb begin
    next_st = st;
    next_st.div = st.div + 6'h01;
    next_st.en_div4 = ((st.div & `CTM_DIV4_MASK) == `CTM_DIV4_MASK);
    next_st.en_div16 = ((st.div & `CTM_DIV16_MASK) == `CTM_DIV16_MASK);
    next_st.en_div64 = ((st.div & `CTM_DIV64_MASK) == `CTM_DIV64_MASK);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign en_div4_o = st.en_div4;
  assign en_div16_o = st.en_div16;
  assign en_div64_o = st.en_div64;

endmodule // ctm_prescale

// ===== testbench/ctm_timer_checker.sv
// Port-level assertions of the compact timer
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_timer_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [`CTM_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_inverted_pin_o,
  input wire logic match_a_irq_o,
  input wire logic match_p_irq_o
);
  logic [7:0] c0;
  logic [7:0] c1;
  logic pin;
  assign pin = timer_output_pin_o;
  // Shadow control bytes; period high writes are not mirrored, so c0[2:0] is unused
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 3'h0) begin
      c0 <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 3'h1) begin
      c1 <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_INV: assert property (timer_output_inverted_pin_o == !pin)
    else $error("pin pair not inverse");
  AST_TOGGLE: assert property (c1[7:4] == 4'h3 && match_a_irq_o && !$past(reg_wr_i)
    |-> pin != $past(pin)) else $error("no toggle on match");
  AST_SETCLR: assert property (c1[7:6] == 2'h0 && (c1[5] ^ c1[4]) && match_a_irq_o && !$past(reg_wr_i)
    |-> pin == (c1[5] ^ c1[2])) else $error("set or clear wrong");
  AST_PSPACE: assert property (match_p_irq_o |=> !match_p_irq_o [*8])
    else $error("period pulses too close");
  AST_QUIET: assert property ((!c0[3] || c0[7]) [*3] |-> !match_a_irq_o && !match_p_irq_o)
    else $error("pulse while stopped");
  AST_HIRD: assert property ($past(reg_rd_i) && $past(reg_addr_i[0]) && $past(reg_addr_i) != 3'h1
    |-> reg_rdata_o[7:2] == 6'h00) else $error("high byte too wide");
  AST_CTRL: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 3'h1
    |-> reg_rdata_o == $past(c1)) else $error("control read wrong");
  AST_RDIDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data without read");
  AST_RESTORE: assert property ($rose(c0[3]) && c1[7:6] == 2'h0
    |-> ##[0:2] pin == (c1[3] ^ c1[2])) else $error("initial level lost");
endmodule // ctm_timer_checker

bind ctm_timer ctm_timer_checker i_ctm_timer_checker (
  .clk_sys_i,
  .rst_b_i,
  .reg_addr_i,
  .reg_wdata_i,
  .reg_wr_i,
  .reg_rd_i,
  .reg_rdata_o,
  .timer_output_pin_o,
  .timer_output_inverted_pin_o,
  .match_a_irq_o,
  .match_p_irq_o
);

// ===== testbench/ctm_timer_tb.sv
// Self-checking bench of the compact timer
`timescale 1ns/1ps
module ctm_timer_tb;
  logic clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, ext, sub, p;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, rd;
  logic timer_output_pin_o, timer_output_inverted_pin_o, match_a_irq_o, match_p_irq_o;
  int errors, check_count, n, k, g;
  int dv[4] = '{4, 1, 16, 64};

  ctm_timer i_ctm_timer (
    .clk_sys_i,
    .rst_b_i,
    .reg_addr_i,
    .reg_wdata_i,
    .reg_wr_i,
    .reg_rd_i,
    .reg_rdata_o,
    .compact_ext_clock_pin_i(ext),
    .sub_clock_i(sub),
    .timer_output_pin_o,
    .timer_output_inverted_pin_o,
    .match_a_irq_o,
    .match_p_irq_o
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rdr(input logic [2:0] a);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask

  task automatic on(input logic [7:0] c);
    wr(3'h0, 8'h00);
    wr(3'h0, c);
  endtask

  // Cycles between two consecutive pulses; first pulse after a restart is partial
  task automatic gap(input bit pa, output int c);
    k = 0;
    while ((pa ? match_p_irq_o : match_a_irq_o) !== 1'b1 && k < 20000) begin
      @(posedge clk_sys_i);
      k++;
    end
    c = 0;
    do begin
      @(posedge clk_sys_i);
      c++;
    end while ((pa ? match_p_irq_o : match_a_irq_o) !== 1'b1 && c < 20000);
  endtask

  // Next pulse strictly after the current edge
  task automatic nxt(input bit pa);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while ((pa ? match_p_irq_o : match_a_irq_o) !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      errors++;
      $display("mismatch at %0t: no pulse", $time);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // About 35k cycles expected
  initial begin
    #1200000;
    errors++;
    $display("mismatch at %0t: watchdog", $time);
    finish_test();
  end

  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, ext, sub} = 5'h00;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdr(3'h0);
    chk(rd, 8'h00);
    rdr(3'h1);
    chk(rd, 8'h00);
    chk(timer_output_inverted_pin_o, 1'b1);
    $display("test reset done");
    wr(3'h4, 8'hA5);
    wr(3'h5, 8'h02);
    wr(3'h4, 8'h11);
    rdr(3'h5);
    chk(rd, 8'h02);
    rdr(3'h4);
    chk(rd, 8'hA5);
    wr(3'h6, 8'h80);
    wr(3'h7, 8'h01);
    rdr(3'h0);
    chk(rd, 8'h03);
    rdr(3'h7);
    chk(rd, 8'h01);
    rdr(3'h6);
    chk(rd, 8'h80);
    $display("test pairs done");
    for (n = 0; n < 8; n++) begin
      on(8'h18 | n[7:0]);
      gap(1, g);
      chk(g, n == 0 ? 1024 : n * 128);
    end
    for (n = 0; n < 4; n++) begin
      on({1'b0, n[2:0], 4'h9});
      gap(1, g);
      chk(g, 128 * dv[n]);
    end
    $display("test periods done");
    for (n = 4; n < 8; n++) begin
      on({1'b0, n[2:0], 4'h8});
      repeat (5) begin
        repeat (4) @(posedge clk_sys_i);
        ext <= 1'b1;
        sub <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        ext <= 1'b0;
        sub <= 1'b0;
      end
      repeat (6) @(posedge clk_sys_i);
      rdr(3'h3);
      chk(rd, 8'h00);
      rdr(3'h2);
      chk(rd, 8'h05);
    end
    $display("test sources done");
    wr(3'h4, 8'h0F);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'h31);
    on(8'h18);
    gap(0, g);
    chk(g, 15);
    #1 p = timer_output_pin_o;
    nxt(0);
    #1 chk(timer_output_pin_o, !p);
    wr(3'h1, 8'h21);
    gap(0, g);
    #1 chk(timer_output_pin_o, 1'b1);
    wr(3'h1, 8'h11);
    gap(0, g);
    #1 chk(timer_output_pin_o, 1'b0);
    wr(3'h1, 8'h08);
    on(8'h18);
    repeat (3) @(posedge clk_sys_i);
    chk(timer_output_pin_o, 1'b1);
    $display("test compare done");
    wr(3'h4, 8'h20);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'hA8);
    on(8'h19);
    gap(1, g);
    k = 0;
    repeat (128) begin
      @(posedge clk_sys_i);
      k += timer_output_pin_o;
    end
    chk(k, 32);
    wr(3'h1, 8'h9C);
    repeat (2) @(posedge clk_sys_i);
    chk(timer_output_pin_o, 1'b0);
    chk(timer_output_inverted_pin_o, 1'b1);
    wr(3'h1, 8'h8C);
    repeat (2) @(posedge clk_sys_i);
    chk(timer_output_pin_o, 1'b1);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h01);
    wr(3'h1, 8'hAA);
    on(8'h19);
    gap(0, g);
    chk(g, 256);
    k = 0;
    repeat (256) begin
      @(posedge clk_sys_i);
      k += timer_output_pin_o;
    end
    chk(k, 128);
    $display("test pwm done");
    wr(3'h1, 8'hC0);
    on(8'h98);
    #1 p = timer_output_pin_o;
    repeat (50) @(posedge clk_sys_i);
    rdr(3'h3);
    chk(rd, 8'h00);
    rdr(3'h2);
    chk(rd, 8'h00);
    wr(3'h0, 8'h18);
    gap(1, g);
    chk(g, 1024);
    chk(timer_output_pin_o, p);
    $display("test timer done");
    finish_test();
  end
endmodule // ctm_timer_tb
